// File: bench/card_host_status_flags_test.sv
// Self-checking bench of the status-flag block over AXI4-Lite.
// Assumes the card model on the pins and event pulses driven by the bench.
`timescale 1ns/1ps
`include "card_host_status_params.svh"

module card_host_status_flags_test
	import card_host_status_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, card_clk, card_dat0;
	logic [1:0] bresp, rresp;
	word_type wdata = '0;
	word_type rdata;
	// Pulses and levels by status bit; spares: 10 data command, 11 response end, 20 start, 22 CRC done
	// Level spare: lv bit 11 is control ready
	word_type ev = '0;
	word_type lv = 32'h0c000804;
	logic write_op = 1'b0, c_wait = 1'b0, d_wait = 1'b0, r_wait = 1'b0, run = 1'b0, no_buf = 1'b0;
	int num_errors = 0, n_checks = 0;

	always #50 aclk = ~aclk;

	card_host_status_flags dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.card_clk(card_clk), .card_dat0(card_dat0),
		.boot_ack_fault_evt(ev[29]), .boot_ack_seen_evt(ev[28]), .tx_underflow_evt(ev[31]),
		.rx_overflow_evt(ev[30]), .dma_buffer_done_evt(ev[25]), .dma_block_overflow_evt(ev[24]),
		.data_crc_fault_evt(ev[21]), .reply_endbit_evt(ev[19]), .reply_crc_evt(ev[18]),
		.reply_direction_evt(ev[17]), .reply_index_evt(ev[16]), .ata_completion_evt(ev[13]),
		.slot_a_irq_evt(ev[8]), .slot_b_irq_evt(ev[9]), .block_done_evt(ev[3]),
		.command_sent_evt(ev[0]), .data_cmd_start(ev[10]), .response_end(ev[11]),
		.data_start(ev[20]), .data_crc_done(ev[22]), .write_op(write_op),
		.control_ready(lv[11]), .bus_idle(lv[27]), .fifo_empty(lv[26]),
		.dma_tx_empty(lv[15]), .dma_rx_full(lv[14]), .dma_tx_done(lv[7]), .dma_rx_done(lv[6]),
		.io_read_wait(lv[12]), .tx_word_done(lv[2]), .rx_word_ready(lv[1]),
		.completion_wait(c_wait), .data_wait(d_wait), .reply_wait(r_wait)
	);

	card_model card (.run(run), .no_buffer(no_buf), .card_clk(card_clk), .card_dat0(card_dat0));

	// ==========================================
	// Helpers
	task automatic chk(input word_type got, input word_type exp, input word_type mask);
		n_checks++;
		if ((got & mask) !== (exp & mask)) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h under %h", $time, got, exp, mask);
		end
	endtask

	// Both halves offered together; bready held until the answer is sampled
	task automatic wr(input logic [11:0] a, input word_type d, input logic [1:0] er = resp_okay);
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er}, 32'h3);
	endtask

	// Optional pulse lands on the edge that takes the address
	task automatic rd(input logic [11:0] a, input word_type exp, input word_type mask,
			input logic [1:0] er = resp_okay, input word_type at_take = '0);
		logic [1:0] r;
		word_type d;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ev <= at_take;
		forever begin
			@(posedge aclk);
			ev <= '0;
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		chk({30'h0, r}, {30'h0, er}, 32'h3);
		chk(d, exp, mask);
	endtask

	task automatic st(input word_type exp, input word_type mask);
		rd(`STATUS_OFFSET, exp, mask);
	endtask

	task automatic pulse(input word_type m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= '0;
	endtask

	// Card edges plus room for the pin synchronisers
	task automatic card_edges(input int n);
		repeat (n) @(posedge card_clk);
		repeat (5) @(posedge aclk);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		st(`STATUS_RESET, 32'hffffffff);
		rd(`CFG_OFFSET, 32'h0, 32'hffffffff);
	endtask

	task automatic t_read_clear;
		int bits[8] = '{29, 28, 25, 24, 21, 13, 9, 8};
		foreach (bits[i]) begin
			pulse(32'h1 << bits[i]);
			st(32'h1 << bits[i], 32'h33e02300);
			st(32'h0, 32'h33e02300);
		end
		rd(`STATUS_OFFSET, 32'h0, 32'h0, resp_okay, 32'h2000);
		st(32'h2000, 32'h2000);
		st(32'h0, 32'h2000);
	endtask

	task automatic t_cmd_clear;
		pulse(32'h000f0001);
		st(32'h000f0001, 32'h001f0001);
		st(32'h000f0001, 32'h001f0001);
		wr(`CMD_OFFSET, 32'h0);
		st(32'h0, 32'h001f0001);
		pulse(32'h1);
		st(32'h1, 32'h1);
	endtask

	task automatic t_flow;
		wr(`CFG_OFFSET, 32'h0);
		pulse(32'hc0000000);
		st(32'hc0000000, 32'hc0000000);
		st(32'hc0000000, 32'hc0000000);
		pulse(32'h400);
		st(32'h0, 32'hc0000000);
		wr(`CFG_OFFSET, 32'h10);
		rd(`CFG_OFFSET, 32'h10, 32'hffffffff);
		pulse(32'hc0000000);
		pulse(32'h400);
		st(32'hc0000000, 32'hc0000000);
		st(32'h0, 32'hc0000000);
	endtask

	task automatic t_levels;
		@(posedge aclk);
		lv <= 32'h0000d0c2;
		st(32'h0000d0c2, 32'h0c00d0c6);
		st(32'h0000d0c2, 32'h0c00d0c6);
		@(posedge aclk);
		lv <= 32'h0c000004;
		st(32'h04000004, 32'h0c00d0c6);
		@(posedge aclk);
		lv <= 32'h0c000804;
		st(32'h0c000004, 32'h0c00d0c6);
	endtask

	task automatic t_data_phase;
		pulse(32'h100000);
		st(32'h10, 32'h10);
		pulse(32'h400000);
		st(32'h0, 32'h10);
		pulse(32'h500000);
		st(32'h0, 32'h10);
		@(posedge aclk);
		write_op <= 1'b1;
		pulse(32'h8);
		st(32'h8, 32'h8);
		st(32'h0, 32'h8);
		@(posedge aclk);
		write_op <= 1'b0;
		pulse(32'h8);
		st(32'h0, 32'h8);
	endtask

	// Card stays busy over several edges before it frees a buffer
	task automatic t_busy;
		@(posedge aclk);
		write_op <= 1'b1;
		no_buf <= 1'b1;
		run <= 1'b1;
		pulse(32'h800);
		card_edges(3);
		st(32'h0, 32'h20);
		@(posedge aclk);
		no_buf <= 1'b0;
		card_edges(2);
		st(32'h20, 32'h20);
		@(posedge aclk);
		write_op <= 1'b0;
	endtask

	// Limits: completion 2 edges, data 2 x 16, reply 5 then 64
	task automatic t_timeouts;
		wr(`CTO_OFFSET, 32'h02);
		rd(`CTO_OFFSET, 32'h02, 32'hffffffff);
		wr(`DTO_OFFSET, 32'h12);
		@(posedge aclk);
		c_wait <= 1'b1;
		d_wait <= 1'b1;
		card_edges(1);
		st(32'h0, 32'h00c00000);
		card_edges(5);
		c_wait <= 1'b0;
		st(32'h00800000, 32'h00c00000);
		st(32'h0, 32'h00800000);
		card_edges(30);
		d_wait <= 1'b0;
		st(32'h00400000, 32'h00400000);
		st(32'h0, 32'h00400000);
		wr(`CMD_OFFSET, 32'h0);
		r_wait <= 1'b1;
		card_edges(3);
		st(32'h0, 32'h100000);
		card_edges(5);
		r_wait <= 1'b0;
		st(32'h100000, 32'h100000);
		wr(`CMD_OFFSET, 32'h1000);
		st(32'h0, 32'h100000);
		r_wait <= 1'b1;
		card_edges(10);
		st(32'h0, 32'h100000);
		card_edges(60);
		r_wait <= 1'b0;
		st(32'h100000, 32'h100000);
		run <= 1'b0;
	endtask

	task automatic t_refuse;
		wr(`STATUS_OFFSET, 32'hffffffff, resp_slverr);
		st(32'h00100000, 32'hf3ff2308);
		rd(`CMD_OFFSET, 32'h0, 32'hffffffff, resp_slverr);
		rd(12'h0f0, 32'h0, 32'h0, resp_slverr);
		wr(12'h0f0, 32'h1, resp_slverr);
	endtask

	task automatic wrap_up;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_read_clear;
		t_cmd_clear;
		t_flow;
		t_levels;
		t_data_phase;
		t_busy;
		t_timeouts;
		t_refuse;
		wrap_up;
	end

	// Watchdog: the run needs about 1300 cycles, this allows 20000
	initial begin
		#2000000;
		num_errors++;
		wrap_up;
	end
endmodule

// File: bench/card_model.sv
// Card side of the card bus: the clock pin and data line 0.
// Assumes the bench gates the clock and says when no receive buffer is free.
`timescale 1ns/1ps

module card_model (
	// Control from the bench
	input wire logic run,
	input wire logic no_buffer,
	// Card pins
	output logic card_clk,
	output logic card_dat0
);
	// ==========================================
	// Clock
	// Odd start offset keeps its edges clear of aclk; it rests low between frames
	initial begin
		card_clk = 1'b0;
		#37;
		forever begin
			#400;
			card_clk = run ? ~card_clk : 1'b0;
		end
	end

	// ==========================================
	// Busy signalling
	// busy hold
	// Low while no buffer is free; driven high again once released
	assign card_dat0 = no_buffer ? 1'b0 : 1'b1;
endmodule

// File: hdl/card_host_status_flags.sv
// Status word of the card host interface with its AXI4-Lite slave and timeout counters.
// Assumes event pulses and levels come from card engine logic on aclk; the
// card clock and data line 0 arrive from pins and are synchronised here.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "card_host_status_params.svh"

module card_host_status_flags
	import card_host_status_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Card pins, asynchronous
	input wire logic card_clk,
	input wire logic card_dat0,
	// Event pulses from the card engine
	input wire logic boot_ack_fault_evt,
	input wire logic boot_ack_seen_evt,
	input wire logic tx_underflow_evt,
	input wire logic rx_overflow_evt,
	input wire logic dma_buffer_done_evt,
	input wire logic dma_block_overflow_evt,
	input wire logic data_crc_fault_evt,
	input wire logic reply_endbit_evt,
	input wire logic reply_crc_evt,
	input wire logic reply_direction_evt,
	input wire logic reply_index_evt,
	input wire logic ata_completion_evt,
	input wire logic slot_a_irq_evt,
	input wire logic slot_b_irq_evt,
	input wire logic block_done_evt,
	input wire logic command_sent_evt,
	input wire logic data_cmd_start,
	input wire logic response_end,
	input wire logic data_start,
	input wire logic data_crc_done,
	// Live levels from the card engine
	input wire logic write_op,
	input wire logic control_ready,
	input wire logic bus_idle,
	input wire logic fifo_empty,
	input wire logic dma_tx_empty,
	input wire logic dma_rx_full,
	input wire logic dma_tx_done,
	input wire logic dma_rx_done,
	input wire logic io_read_wait,
	input wire logic tx_word_done,
	input wire logic rx_word_ready,
	// Wait windows timed against the card clock
	input wire logic completion_wait,
	input wire logic data_wait,
	input wire logic reply_wait
);

	// ==========================================
	// Declarations
	word_type status_reg, status_next;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	axi_resp_type bresp_reg, rresp_reg;
	word_type rdata_reg, wdata_reg;
	logic [3:0] wstrb_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic aw_held_reg, w_held_reg;
	logic cfg_ferr_reg, lat_sel_reg;
	logic [6:0] cto_reg, dto_reg;
	logic clk_s1_reg, clk_s2_reg, clk_prev_reg, dat_s1_reg, dat_s2_reg;
	tcount_type to_cnt_reg [3];
	tcount_type to_cnt_next [3];
	tcount_type to_limit [3];
	logic [2:0] wait_vec, to_expire;
	logic card_edge, aw_fire, w_fire, wr_do, ar_fire, rd_fire, cmd_fire;
	logic aw_held_next, w_held_next, rvalid_next;
	logic wr_cfg, wr_cto, wr_dto, wr_cmd, wr_ok;
	logic rd_status, rd_cfg, rd_cto, rd_dto, rd_ok;
	word_type rd_mux, set_vec, clr_vec, live_vec, read_clr;
	logic card_ready_next, data_phase_next;

	// ==========================================
	// Pin synchronisers
	// Card clock and line 0 each pass two flops before any logic sees them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
			clk_prev_reg <= 1'b0;
			dat_s1_reg <= 1'b1;
			dat_s2_reg <= 1'b1;
		end else begin
			clk_s1_reg <= card_clk;
			clk_s2_reg <= clk_s1_reg;
			clk_prev_reg <= clk_s2_reg;
			dat_s1_reg <= card_dat0;
			dat_s2_reg <= dat_s1_reg;
		end
	end

	// Rising card clock edge, seen from the second stage onward
	assign card_edge = clk_s2_reg & ~clk_prev_reg;

	// ==========================================
	// Timeout counters
	// Limit is cycles shifted by the scale code; table of multipliers as shifts
	function automatic tcount_type to_limit_f(input logic [6:0] f);
		tcount_type base;
		base = {21'h000000, f[`TO_CYC_MSB:0]};
		case (f[`TO_SCALE_MSB:4])
			3'h0: to_limit_f = base;
			3'h1: to_limit_f = base << 4;
			3'h2: to_limit_f = base << 7;
			3'h3: to_limit_f = base << 8;
			3'h4: to_limit_f = base << 10;
			3'h5: to_limit_f = base << 12;
			3'h6: to_limit_f = base << 16;
			default: to_limit_f = base << 20;
		endcase
	endfunction

	// Index 0 completion, 1 data, 2 reply latency
	assign wait_vec = {reply_wait, data_wait, completion_wait};
	assign to_limit[0] = to_limit_f(cto_reg);
	assign to_limit[1] = to_limit_f(dto_reg);
	assign to_limit[2] = lat_sel_reg ? `REPLY_LAT_LONG : `REPLY_LAT_SHORT;

	// Counter stops one past the limit so each wait fires only once
	genvar i;
	for (i = 0; i < 3; i++) begin : g_timeout
		assign to_cnt_next[i] = !wait_vec[i] ? '0 :
			(card_edge && to_cnt_reg[i] <= to_limit[i]) ? to_cnt_reg[i] + 25'h0000001 : to_cnt_reg[i];
		assign to_expire[i] = wait_vec[i] && card_edge && (to_cnt_reg[i] == to_limit[i]);
		always_ff @(posedge aclk) begin
			if (!aresetn)
				to_cnt_reg[i] <= '0;
			else
				to_cnt_reg[i] <= to_cnt_next[i];
		end
	end

	// ==========================================
	// AXI4-Lite handshakes
	assign aw_fire = s_axi_awvalid & awready_reg;
	assign w_fire = s_axi_wvalid & wready_reg;
	// Write performed once both halves are held and no answer waits
	assign wr_do = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign aw_held_next = aw_held_reg ? ~wr_do : aw_fire;
	assign w_held_next = w_held_reg ? ~wr_do : w_fire;
	assign ar_fire = s_axi_arvalid & arready_reg;
	assign rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);

	// Write address decode
	assign wr_cfg = awaddr_reg == `CFG_OFFSET;
	assign wr_cto = awaddr_reg == `CTO_OFFSET;
	assign wr_dto = awaddr_reg == `DTO_OFFSET;
	assign wr_cmd = awaddr_reg == `CMD_OFFSET;
	assign wr_ok = wr_cfg | wr_cto | wr_dto | wr_cmd;
	assign cmd_fire = wr_do & wr_cmd;

	// Read address decode; the command register is write-only
	assign rd_status = s_axi_araddr == `STATUS_OFFSET;
	assign rd_cfg = s_axi_araddr == `CFG_OFFSET;
	assign rd_cto = s_axi_araddr == `CTO_OFFSET;
	assign rd_dto = s_axi_araddr == `DTO_OFFSET;
	assign rd_ok = rd_status | rd_cfg | rd_cto | rd_dto;
	assign rd_fire = ar_fire & rd_status;
	assign rd_mux = rd_status ? status_reg :
		rd_cfg ? {27'h0000000, cfg_ferr_reg, 4'h0} :
		rd_cto ? {25'h0000000, cto_reg} :
		rd_dto ? {25'h0000000, dto_reg} : 32'h00000000;

	// Write side of the slave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= resp_okay;
		end else begin
			awready_reg <= ~aw_held_next;
			wready_reg <= ~w_held_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			if (aw_fire)
				awaddr_reg <= s_axi_awaddr;
			if (w_fire) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_do) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? resp_okay : resp_slverr;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Software-written control fields, byte lane 0 and 1 only
	// The latency select stands apart from the lane 0 fields, so that a command
	// write with lane 0 disabled still reaches it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ferr_reg <= 1'b0;
			lat_sel_reg <= 1'b0;
			cto_reg <= 7'h00;
			dto_reg <= 7'h00;
		end else begin
			if (wr_do && wstrb_reg[0]) begin
				if (wr_cfg)
					cfg_ferr_reg <= wdata_reg[`CFG_FERR_BIT];
				if (wr_cto)
					cto_reg <= wdata_reg[6:0];
				if (wr_dto)
					dto_reg <= wdata_reg[6:0];
			end
			if (cmd_fire && wstrb_reg[1])
				lat_sel_reg <= wdata_reg[`CMD_LAT_BIT];
		end
	end

	// Read side; data is the addressed register as it stood at the taking edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= resp_okay;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_fire) begin
				rdata_reg <= rd_mux;
				rresp_reg <= rd_ok ? resp_okay : resp_slverr;
			end
		end
	end

	// ==========================================
	// Sticky flags
	// Event bits; each set wins over a clear in the same cycle
	assign set_vec = {tx_underflow_evt, rx_overflow_evt, boot_ack_fault_evt, boot_ack_seen_evt,
		2'h0, dma_buffer_done_evt, dma_block_overflow_evt,
		to_expire[0], to_expire[1], data_crc_fault_evt, to_expire[2],
		reply_endbit_evt, reply_crc_evt, reply_direction_evt, reply_index_evt,
		2'h0, ata_completion_evt, 3'h0, slot_b_irq_evt, slot_a_irq_evt,
		4'h0, block_done_evt & write_op, 2'h0, command_sent_evt};

	assign read_clr = rd_fire ? (status_reg & (`READ_CLEAR_MASK | (cfg_ferr_reg ? `FLOW_CLEAR_MASK : 32'h0))) : '0;
	assign clr_vec = read_clr | (cmd_fire ? `CMD_CLEAR_MASK : '0) |
		((data_cmd_start && !cfg_ferr_reg) ? `FLOW_CLEAR_MASK : '0);

	assign live_vec = {4'h0, control_ready & bus_idle, fifo_empty, 10'h000,
		dma_tx_empty, dma_rx_full, 1'b0, io_read_wait, 4'h0,
		dma_tx_done, dma_rx_done, 3'h0, tx_word_done, rx_word_ready, 1'b0};

	// card ready; response end wins over a release seen the same edge
	assign card_ready_next = (response_end && write_op) ? 1'b0 :
		(card_edge && dat_s2_reg) ? 1'b1 : status_reg[5];
	// data phase ends with the CRC16 work
	assign data_phase_next = data_crc_done ? 1'b0 : data_start ? 1'b1 : status_reg[4];

	assign status_next = (((status_reg & ~clr_vec) | set_vec) & `STICKY_MASK) | live_vec |
		{26'h0000000, card_ready_next, data_phase_next, 4'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			status_reg <= `STATUS_RESET;
		else
			status_reg <= status_next;
	end

	// ==========================================
	// Outputs, all from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ==========================================
	// Assertions
	a_boot_fault_set: assert property (
		@(posedge aclk) disable iff (!aresetn) boot_ack_fault_evt |=> status_reg[29])
		else $error("boot fault not set");
	a_boot_seen_clear: assert property (
		@(posedge aclk) disable iff (!aresetn) rd_fire && !boot_ack_seen_evt |=> !status_reg[28])
		else $error("boot seen not cleared by read");
	a_underflow_cmd_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		data_cmd_start && !cfg_ferr_reg && !tx_underflow_evt |=> !status_reg[31])
		else $error("underflow not cleared by data command");
	a_overflow_read_mode: assert property (
		@(posedge aclk) disable iff (!aresetn)
		rd_fire && cfg_ferr_reg && !rx_overflow_evt && !data_cmd_start |=> !status_reg[30])
		else $error("overflow not cleared by read");
	a_overflow_keep: assert property (
		@(posedge aclk) disable iff (!aresetn)
		status_reg[30] && !cfg_ferr_reg && !data_cmd_start |=> status_reg[30])
		else $error("overflow lost without data command");
	a_idle_level: assert property (
		@(posedge aclk) disable iff (!aresetn) ##1 status_reg[27] == $past(control_ready && bus_idle))
		else $error("idle bit wrong");
	a_dma_done_set: assert property (
		@(posedge aclk) disable iff (!aresetn) dma_buffer_done_evt |=> status_reg[25] ##1 1'b1)
		else $error("dma done not set");
	a_reply_timeout: assert property (
		@(posedge aclk) disable iff (!aresetn) to_expire[2] |=> status_reg[20])
		else $error("reply timeout not flagged");
	// Latency choice must follow every command write that carries lane 1
	a_latency_select: assert property (
		@(posedge aclk) disable iff (!aresetn) cmd_fire && wstrb_reg[1] |=> lat_sel_reg == $past(wdata_reg[`CMD_LAT_BIT]))
		else $error("latency select not written");
	a_reply_cmd_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		cmd_fire && !reply_index_evt && !reply_endbit_evt |=> !status_reg[16] && !status_reg[19])
		else $error("reply faults not cleared by command write");
	a_live_dma: assert property (
		@(posedge aclk) disable iff (!aresetn) $rose(dma_rx_full) |=> status_reg[14])
		else $error("rx full not live");
	a_event_survives: assert property (
		@(posedge aclk) disable iff (!aresetn) rd_fire && ata_completion_evt |=> status_reg[13])
		else $error("event lost during read");
	a_ready_cleared: assert property (
		@(posedge aclk) disable iff (!aresetn) response_end && write_op |=> !status_reg[5])
		else $error("card ready not cleared");
	a_phase_end: assert property (
		@(posedge aclk) disable iff (!aresetn) data_crc_done |=> !status_reg[4])
		else $error("data phase not ended");
	a_block_end_set: assert property (
		@(posedge aclk) disable iff (!aresetn) block_done_evt && write_op |=> status_reg[3])
		else $error("block end not set");
	a_cmd_sent_set: assert property (
		@(posedge aclk) disable iff (!aresetn) command_sent_evt |=> status_reg[0])
		else $error("command sent not set");
	a_read_answer: assert property (
		@(posedge aclk) disable iff (!aresetn) ar_fire |=> rvalid_reg && rdata_reg == $past(rd_mux))
		else $error("read answer wrong");

endmodule

// File: hdl/card_host_status_params.svh
// Constants of the card host status-flag block: offsets, bit positions,
// reset values and timeout figures.
// Assumes inclusion by bare name from the status-flag module and its bench.
//
// What this block does
// - Corrupted boot acknowledge sets bit 29; a status read clears it.
// - Received boot acknowledge sets bit 28; a status read clears it.
// - Transmit underflow sets bit 31; cleared by data command or read per mode.
// - Receive overflow sets bit 30; cleared by data command or read per mode.
// - Bit 27 high while control is ready and data bus idle.
// - Bit 26 high while the data FIFO is empty.
// - DMA buffer completion sets bit 25; a status read clears it.
// - New block before DMA moved pending one sets bit 24; read clears.
// - Completion wait beyond cycles times scale sets bit 23; read clears.
// - Data wait beyond cycles times scale sets bit 22; read clears.
// - Data CRC16 mismatch in last block sets bit 21; read clears.
// - Reply timeout sets bit 20, missing end bit sets 19; command write clears.
// - Reply CRC7, direction and index faults set bits 18..16; command write clears.
// - DMA buffer and finish bits 15, 14, 7, 6 are live levels.
// - Completion signal on command line sets bit 13; read clears.
// - Bit 12 high while the data bus is in IO read-wait.
// - Slot A or B IO interrupt sets bit 8 or 9; read clears.
// - Writes: bit 5 clears at response end, sets when line 0 busy ends.
// - Bit 4 high during a data transfer, clears when CRC16 work ends.
// - Writes: each completed block with CRC token sets bit 3; read clears.
// - Command fully sent sets bit 0; command write clears it.
// - Bit 2 shows transmit word taken, bit 1 new receive data.
`ifndef CARD_HOST_STATUS_PARAMS_SVH
`define CARD_HOST_STATUS_PARAMS_SVH

// ==========================================
// Register offsets
`define DTO_OFFSET 12'h008
`define CMD_OFFSET 12'h00c
`define CTO_OFFSET 12'h01c
`define STATUS_OFFSET 12'h040
`define CFG_OFFSET 12'h054

// ==========================================
// Reset values and masks
`define STATUS_RESET 32'h0c000025
`define READ_CLEAR_MASK 32'h33e02308
`define CMD_CLEAR_MASK 32'h001f0001
`define FLOW_CLEAR_MASK 32'hc0000000
`define STICKY_MASK 32'hf3ff2309

// ==========================================
// Field positions
`define CFG_FERR_BIT 4
`define CMD_LAT_BIT 12
`define TO_CYC_MSB 3
`define TO_SCALE_MSB 6

// ==========================================
// Reply latency limits in card clock edges
`define REPLY_LAT_SHORT 25'h0000005
`define REPLY_LAT_LONG 25'h0000040

`endif

// File: hdl/card_host_status_pkg.sv
// Types shared by the card host status-flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package card_host_status_pkg;
	typedef logic [31:0] word_type;
	typedef logic [24:0] tcount_type;
	typedef enum logic [1:0] {
		resp_okay = 2'h0,
		resp_slverr = 2'h2
	} axi_resp_type;
endpackage
